// [rtl/return_address_stack.sv]
// The strobed register port was decided locally.
`include "ras_defines.svh"

module return_address_stack
	import ras_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic rstn,
	// Reset sources
	input wire logic por_n,
	input wire logic wdt_overflow,
	input wire logic brownout,
	// Sequencer requests
	input wire logic call_push,
	input wire logic irq_push,
	input wire logic ret_pop,
	input wire logic return_from_interrupt_pop,
	input wire logic [10:0] pc_in,
	// Register port
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	// Core outputs
	output logic [10:0] pc_out,
	output logic pc_load,
	output logic global_irq_enable,
	output logic [2:0] stack_level_pointer,
	output logic run_enable,
	output logic sys_reset
);

	// Saved address storage, split high and low
	// Cleared on reset, so a stray pop returns zero rather than junk
	logic [`HIGH_W-1:0] saved_addr_high [`DEPTH];
	logic [7:0] saved_addr_low [`DEPTH];
	// Reset source synchronisers, three stages each
	logic [2:0] por_sync;
	logic [2:0] wdt_sync;
	logic [2:0] bod_sync;
	// Combined soft reset request
	logic any_reset;
	// Boot sequencer
	boot_e boot;
	logic [7:0] boot_cnt;
	// Decoded requests
	logic push;
	logic pop;
	logic [2:0] next_ptr;
	logic [2:0] push_slot;
	logic [2:0] pop_slot;
	logic ptr_wr;
	logic entry_wr;
	logic [2:0] entry_idx;
	logic entry_hi;

	// Pin inputs pass three stages; a reset request counts once stages 1 and 2 agree.
	// Stages reset low, so power-good reads as absent until the pin has
	// been seen high twice: the core stays halted right after rstn.
	pin_sync por_pin_inst (
		.clk(clk),
		.rstn(rstn),
		.pin(por_n),
		.stages(por_sync)
	);
	pin_sync wdt_pin_inst (
		.clk(clk),
		.rstn(rstn),
		.pin(wdt_overflow),
		.stages(wdt_sync)
	);
	pin_sync bod_pin_inst (
		.clk(clk),
		.rstn(rstn),
		.pin(brownout),
		.stages(bod_sync)
	);

	// Any of the three sources resets the whole system
	// Watchdog and brown-out are active high, power-good active low
	// A one-cycle glitch on a pin never resets the core
	assign any_reset = (!por_sync[2] && !por_sync[1]) ||
		(wdt_sync[2] && wdt_sync[1]) ||
		(bod_sync[2] && bod_sync[1]);

	// Register strobe decode
	// Entry writes never move the pointer; software owns that layout
	assign ptr_wr = reg_wr && (reg_addr == `ADDR_STACK_POINTER);
	assign entry_wr = reg_wr &&
		((reg_addr & `ADDR_STACK_MASK) == `ADDR_STACK_BASE);
	// Entry n lives at F0+2n (high) and F0+2n+1 (low)
	assign entry_idx = reg_addr[3:1];
	assign entry_hi = !reg_addr[0];

	// Requests only count while the core runs; earlier ones are dropped
	// because the sequencer is not fetching yet
	assign push = run_enable && (call_push || irq_push);
	assign pop = run_enable && (ret_pop || return_from_interrupt_pop);
	// Level n stores into entry n-1: a push at pointer p fills entry
	// 7 - p, so 111 fills entry 0 and 000 fills entry 7
	assign push_slot = 3'h7 - stack_level_pointer;
	// The top entry is the one the last push filled, one pointer step
	// above: entry 6 - p, modulo 8
	assign pop_slot = 3'h6 - stack_level_pointer;
	// Push and pop together cancel out the pointer move
	// Wrapping below 000 is silent; nothing records an overflow
	always_comb begin
		next_ptr = stack_level_pointer;
		if (push && !pop) begin
			next_ptr = stack_level_pointer - 3'h1;
		end else if (pop && !push) begin
			next_ptr = stack_level_pointer + 3'h1;
		end
	end

	// Boot sequence: stabilise, init, warm up, run
	// A reset source held for a few cycles restarts the whole sequence
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			boot <= st_power_wait;
			boot_cnt <= 8'h00;
		end else if (any_reset) begin
			// Reset holds the core halted
			boot <= st_power_wait;
			boot_cnt <= 8'h00;
		end else begin
			unique case (boot)
				st_power_wait: begin
					if (boot_cnt == 8'(`STABLE_CYC - 1)) begin
						boot <= st_init;
						boot_cnt <= 8'h00;
					end else begin
						boot_cnt <= boot_cnt + 8'h01;
					end
				end
				st_init: begin
					// One cycle for register initialisation
					boot <= st_warmup;
				end
				st_warmup: begin
					if (boot_cnt == 8'(`WARMUP_CYC - 1)) begin
						boot <= st_run;
						boot_cnt <= 8'h00;
					end else begin
						boot_cnt <= boot_cnt + 8'h01;
					end
				end
				st_run: begin
					// Stays here until the next reset
					boot_cnt <= 8'h00;
				end
			endcase
		end
	end

	// Run flag and system reset flag come from flops
	// Registered, so run_enable lags the boot state by one cycle
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			run_enable <= 1'b0;
			sys_reset <= 1'b1;
		end else begin
			run_enable <= (boot == st_run) && !any_reset;
			sys_reset <= any_reset || (boot != st_run);
		end
	end

	// Global interrupt enable; cleared by any reset and by init
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			global_irq_enable <= `IRQ_EN_RESET;
		end else if (any_reset || boot == st_init) begin
			global_irq_enable <= `IRQ_EN_RESET;
		end else if (ptr_wr) begin
			// Written even when a push or pop moves the pointer
			global_irq_enable <= reg_wdata[`IRQ_EN_BIT];
		end
	end

	// Pointer; hardware moves beat a software write in the same cycle
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			stack_level_pointer <= `PTR_RESET;
		end else if (any_reset || boot == st_init) begin
			stack_level_pointer <= `PTR_RESET;
		end else if (push || pop) begin
			stack_level_pointer <= next_ptr;
		end else if (ptr_wr) begin
			// Software may set the pointer, e.g. to 111 at program start
			stack_level_pointer <= reg_wdata[`PTR_MSB:0];
		end
	end

	// Stack storage; a push without a pop wins over a software write to the same entry
	// Init clears every entry, so each boot starts from a clean stack
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			for (int i = 0; i < `DEPTH; i++) begin
				saved_addr_high[i] <= 3'h0;
				saved_addr_low[i] <= 8'h00;
			end
		end else if (any_reset || boot == st_init) begin
			for (int i = 0; i < `DEPTH; i++) begin
				saved_addr_high[i] <= 3'h0;
				saved_addr_low[i] <= 8'h00;
			end
		end else begin
			if (entry_wr) begin
				if (entry_hi) begin
					saved_addr_high[entry_idx] <= reg_wdata[`HIGH_W-1:0];
				end else begin
					saved_addr_low[entry_idx] <= reg_wdata;
				end
			end
			// Overflow silently overwrites, no flag raised
			if (push && !pop) begin
				saved_addr_high[push_slot] <= pc_in[10:8];
				saved_addr_low[push_slot] <= pc_in[7:0];
			end
		end
	end

	// Counter reload on pop; cleared on any reset
	// The popped value holds until the next pop; pc_load marks it
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			pc_out <= `PC_RESET;
			pc_load <= 1'b0;
		end else if (any_reset || boot != st_run) begin
			// Restart from address zero once running
			pc_out <= `PC_RESET;
			pc_load <= 1'b0;
		end else begin
			pc_load <= pop && !push;
			if (pop && !push) begin
				pc_out <= {saved_addr_high[pop_slot],
					saved_addr_low[pop_slot]};
			end
		end
	end

	// Read data one cycle after the strobe; unmapped reads zero
	// Reads have no side effects, so software may poll freely
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			reg_rdata <= 8'h00;
		end else if (reg_rd) begin
			if (reg_addr == `ADDR_STACK_POINTER) begin
				reg_rdata <= {global_irq_enable, 4'h0, stack_level_pointer};
			end else if ((reg_addr & `ADDR_STACK_MASK) == `ADDR_STACK_BASE) begin
				reg_rdata <= entry_hi ? {5'h00, saved_addr_high[entry_idx]} :
					saved_addr_low[entry_idx];
			end else begin
				reg_rdata <= 8'h00;
			end
		end else begin
			reg_rdata <= 8'h00;
		end
	end

endmodule

// Three-stage synchroniser for a pin from outside the clock domain.
// Stage 0 may go metastable; only stage 1 reads it, and the user
// compares stages 1 and 2 so a single-cycle glitch is ignored.
module pin_sync
	import ras_pkg::*;
#(
	// Level all stages take while rstn is low
	parameter logic RESET_LEVEL = 1'b0
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rstn,
	// Raw pin
	input wire logic pin,
	// All three stages, oldest in bit 2
	output logic [2:0] stages
);

	// Shift the pin in once per clock
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			stages <= {3{RESET_LEVEL}};
		end else begin
			// Newest sample enters at bit 0
			stages <= {stages[1:0], pin};
		end
	end

endmodule

// [inc/ras_defines.svh]
`ifndef RAS_DEFINES_SVH
`define RAS_DEFINES_SVH

// Register map (byte addresses on the core register port)
`define ADDR_STACK_POINTER 8'hDF
`define ADDR_STACK_BASE 8'hF0
`define ADDR_STACK_MASK 8'hF0

// Field layout of the pointer register
`define IRQ_EN_BIT 7
`define PTR_MSB 2
`define PTR_W 3

// Reset values
`define PTR_RESET 3'h7
`define IRQ_EN_RESET 1'b0
`define PC_RESET 11'h000

// Stack geometry
`define DEPTH 8
`define ADDR_W 11
`define HIGH_W 3

// Start-up sequencing after reset release
`define STABLE_NS 100
`define WARMUP_NS 200
`define CLK_NS 10
`define STABLE_CYC ((`STABLE_NS + `CLK_NS - 1) / `CLK_NS)
`define WARMUP_CYC ((`WARMUP_NS + `CLK_NS - 1) / `CLK_NS)

`endif

// [inc/ras_pkg.sv]
package ras_pkg;
	// Start-up phases after any reset
	typedef enum logic [1:0] {
		st_power_wait,
		st_init,
		st_warmup,
		st_run
	} boot_e;
	typedef logic [10:0] addr_t;
endpackage

// [bench/return_address_stack_asserts.sv]
module ras_checker (
	// Clock and reset
	input wire logic clk,
	input wire logic rstn,
	// Sequencer requests
	input wire logic call_push,
	input wire logic irq_push,
	input wire logic ret_pop,
	input wire logic return_from_interrupt_pop,
	// Register port
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_rdata,
	// Core outputs
	input wire logic pc_load,
	input wire logic global_irq_enable,
	input wire logic [2:0] stack_level_pointer,
	input wire logic run_enable,
	input wire logic sys_reset
);
	timeunit 1ns;
	timeprecision 1ns;
	// Requests only count while the core runs
	logic psh;
	logic pop;
	assign psh = run_enable & (call_push | irq_push);
	assign pop = run_enable & (ret_pop | return_from_interrupt_pop);
	default clocking @(posedge clk); endclocking
	default disable iff (!rstn);
	a_push_lowers: assert property (psh && !pop |=>
		stack_level_pointer == $past(stack_level_pointer) - 3'h1)
		else $error("push did not lower pointer");
	a_pop_raises: assert property (pop && !psh |=>
		stack_level_pointer == $past(stack_level_pointer) + 3'h1)
		else $error("pop did not raise pointer");
	a_pop_loads: assert property (pop && !psh |=> pc_load)
		else $error("pop gave no load");
	a_load_cause: assert property (pc_load |-> $past(pop && !psh))
		else $error("load without pop");
	a_clash_holds: assert property (psh && pop |=>
		$stable(stack_level_pointer) && !pc_load)
		else $error("push with pop moved pointer");
	a_read_ptr: assert property (reg_rd && reg_addr == 8'hDF |=>
		reg_rdata == {$past(global_irq_enable), 4'h0,
		$past(stack_level_pointer)})
		else $error("pointer read wrong");
	a_read_idle: assert property (!reg_rd |=> reg_rdata == 8'h00)
		else $error("read data outside read slot");
	a_enable_write: assert property (run_enable && reg_wr &&
		reg_addr == 8'hDF |=>
		{global_irq_enable, 7'h00} == ($past(reg_wdata) & 8'h80))
		else $error("enable bit not written");
	a_run_clean: assert property (run_enable |-> !sys_reset)
		else $error("running during reset");
	// Main scenarios reached
	c_clash: cover property (psh && pop);
	c_load: cover property (pc_load);
	c_restart: cover property ($fell(run_enable));
endmodule

bind return_address_stack ras_checker ras_checker_inst (.clk, .rstn,
	.call_push, .irq_push, .ret_pop, .return_from_interrupt_pop, .reg_addr, .reg_wdata,
	.reg_wr, .reg_rd, .reg_rdata, .pc_load, .global_irq_enable,
	.stack_level_pointer, .run_enable, .sys_reset);

// [bench/sequencer_model.sv]
module sequencer_model (
	// Clock
	input wire logic clk,
	// Requests to the stack
	output logic call_push,
	output logic irq_push,
	output logic ret_pop,
	output logic return_from_interrupt_pop,
	output logic [10:0] pc_in
);
	timeunit 1ns;
	timeprecision 1ns;
	initial begin
		{call_push, irq_push, ret_pop, return_from_interrupt_pop} = 4'h0;
		pc_in = 11'h555;
	end
	// One request per edge, kinds as {call, irq, ret, return_from_interrupt}
	task automatic req(input logic [3:0] k, input logic [10:0] pc);
		@(posedge clk);
		{call_push, irq_push, ret_pop, return_from_interrupt_pop} <= k;
		pc_in <= pc;
	endtask
	// Released bus toggles so a stale value never looks valid
	task automatic idle;
		@(posedge clk);
		{call_push, irq_push, ret_pop, return_from_interrupt_pop} <= 4'h0;
		pc_in <= ~pc_in;
	endtask
endmodule

// [bench/return_address_stack_bench.sv]
module return_address_stack_bench;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk = 0, rstn = 0, por_n = 1, wdt_overflow = 0, brownout = 0;
	logic reg_wr = 0, reg_rd = 0;
	logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata;
	logic call_push, irq_push, ret_pop, return_from_interrupt_pop, pc_load;
	logic global_irq_enable, run_enable, sys_reset;
	logic [10:0] pc_in, pc_out;
	logic [2:0] stack_level_pointer;
	int bad_count = 0, compares = 0;
	// Row: kind, pc, pointer after, load, popped value
	typedef struct packed {logic [3:0] k; logic [10:0] pc;
		logic [2:0] ptr; logic ld; logic [10:0] po;} row_s;
	row_s rows [7] = '{{4'h8, 11'h123, 3'h6, 1'b0, 11'h000},
		{4'h4, 11'h456, 3'h5, 1'b0, 11'h000},
		{4'hA, 11'h7FF, 3'h5, 1'b0, 11'h000},
		{4'h8, 11'h789, 3'h4, 1'b0, 11'h000},
		{4'h2, 11'h000, 3'h5, 1'b1, 11'h789},
		{4'h1, 11'h000, 3'h6, 1'b1, 11'h456},
		{4'h2, 11'h000, 3'h7, 1'b1, 11'h123}};
	// Reset sources as {por_n, watchdog, brown-out}
	logic [2:0] srcs [3] = '{3'b000, 3'b110, 3'b101};
	always #5 clk = ~clk;
	sequencer_model seq (.clk, .call_push, .irq_push, .ret_pop,
		.return_from_interrupt_pop, .pc_in);
	return_address_stack return_address_stack_inst (.clk, .rstn, .por_n,
		.wdt_overflow, .brownout, .call_push, .irq_push, .ret_pop,
		.return_from_interrupt_pop, .pc_in, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
		.reg_rdata, .pc_out, .pc_load, .global_irq_enable,
		.stack_level_pointer, .run_enable, .sys_reset);
	task automatic end_sim;
		if (bad_count == 0 && compares > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask
	task automatic chk(input logic [10:0] got, input logic [10:0] exp);
		compares++;
		if (got !== exp) begin
			bad_count++;
			$display("[FAIL] %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		{reg_addr, reg_wdata, reg_wr} <= {a, d, 1'b1};
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask
	// Read data stand only in the cycle after the strobe
	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		@(posedge clk);
		{reg_addr, reg_rd} <= {a, 1'b1};
		@(posedge clk);
		reg_rd <= 1'b0;
		#1 chk(reg_rdata, exp);
	endtask
	// Boot takes about 34 edges; bounded wait
	task automatic wait_run;
		int n;
		n = 0;
		while (run_enable !== 1'b1 && n < 100) begin
			@(posedge clk);
			#1;
			n++;
		end
		if (n == 100) begin
			bad_count++;
			end_sim();
		end
	endtask
	initial begin
		repeat (2) @(posedge clk);
		rstn <= 1'b1;
		#1 chk(stack_level_pointer, 11'h7);
		chk(global_irq_enable, 11'h0);
		chk(sys_reset & ~run_enable, 11'h1);
		wait_run();
		wr(8'hDF, 8'h7F);
		rd(8'hDF, 8'h07);
		wr(8'hDF, 8'h85);
		#1 chk(global_irq_enable, 11'h1);
		rd(8'hDF, 8'h85);
		rd(8'h10, 8'h00);
		wr(8'hDF, 8'h7F);
		foreach (rows[i]) begin
			seq.req(rows[i].k, rows[i].pc);
			seq.idle();
			#1 chk(stack_level_pointer, rows[i].ptr);
			chk(pc_load, rows[i].ld);
			chk(pc_out, rows[i].po);
		end
		// Back-to-back pushes fill all eight levels, then one more
		for (int i = 0; i < 8; i++) begin
			seq.req(4'h8, 11'h5A0 + 11'(i));
		end
		seq.idle();
		#1 chk(stack_level_pointer, 11'h7);
		seq.req(4'h8, 11'h5A8);
		seq.idle();
		#1 chk(stack_level_pointer, 11'h6);
		rd(8'hF2, 8'h05);
		rd(8'hF3, 8'hA1);
		// Ninth push lands on the oldest entry, level 1
		rd(8'hF1, 8'hA8);
		// High part keeps three bits only; low part all eight
		wr(8'hF4, 8'hFF);
		rd(8'hF4, 8'h07);
		wr(8'hF5, 8'h3C);
		rd(8'hF5, 8'h3C);
		// Pop after the wrap returns the ninth value
		seq.req(4'h2, 11'h000);
		seq.idle();
		#1 chk(pc_out, 11'h5A8);
		for (int s = 0; s < 3; s++) begin
			wr(8'hDF, 8'h83);
			@(posedge clk);
			{por_n, wdt_overflow, brownout} <= srcs[s];
			repeat (6) @(posedge clk);
			#1 chk(run_enable, 11'h0);
			chk(stack_level_pointer, 11'h7);
			chk(global_irq_enable, 11'h0);
			chk(pc_out, 11'h000);
			@(posedge clk);
			{por_n, wdt_overflow, brownout} <= 3'b100;
			wait_run();
		end
		end_sim();
	end
	initial begin
		repeat (5000) @(posedge clk);
		bad_count++;
		end_sim();
	end
endmodule
